// ===== bcr_consts.vh
`ifndef BCR_CONSTS_VH
`define BCR_CONSTS_VH
// ----------------------------------------
// offsets and fields
// ----------------------------------------
`define BCR_OFF_FLOOR     2'h0
`define BCR_OFF_ROOF      2'h1
`define BCR_OFF_MODE      2'h2
`define BCR_OFF_RAMP      2'h3
`define BCR_GATE_BIT      7
`define BCR_DISCH_BIT     6
`define BCR_GOOD_BIT      5
`define BCR_ROOF_MODE_BIT 1
// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define BCR_RST_GATE      1'b1
`define BCR_RST_FREE6     1'b0
`define BCR_RST_MODE      6'h00
`define BCR_RST_RAMP      8'h47
`define BCR_OVR_FOLLOW    2'h0
`define BCR_OVR_PWM       2'h2
`define BCR_RAMP_NOW      3'h7
`define BCR_UNMAP_FS      8'h00
`define BCR_UNMAP_HS      8'hff
`define BCR_HS_CODE       5'h01
`endif

// ===== bcr_sync.v
`timescale 1ns/100ps
module bcr_sync (
    // clock and reset
    input  wire       mclk,
    input  wire       reset,
    // pins
    input  wire [2:0] pin_in,
    output reg  [2:0] pin_out
);
    reg [2:0] meta;
    // ----------------------------------------
    // two-stage synchroniser
    // ----------------------------------------
    always @(posedge mclk) begin
        if (reset) begin
            meta    <= 3'h7;
            pin_out <= 3'h7;
        end else begin
            meta    <= pin_in;
            pin_out <= meta;
        end
    end
endmodule // bcr_sync

// ===== bcr_regs.v
`timescale 1ns/100ps
`include "bcr_consts.vh"
module bcr_regs #(
    parameter [5:0] FLOOR_DEFAULT = 6'h10,
    parameter [5:0] ROOF_DEFAULT  = 6'h20,
    parameter [6:0] DEV_ADDR      = 7'h48
) (
    // clock and reset
    input  wire       mclk,
    input  wire       reset,
    // serial bus pins
    input  wire       scl_in,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    // converter pins and status
    input  wire       enable_pin,
    input  wire       voltage_select_pin,
    input  wire       in_regulation,
    // converter controls
    output reg        converter_run,
    output reg        discharge_on,
    output reg        force_pwm,
    output reg  [5:0] target_code,
    output reg  [2:0] ramp_rate_select
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_REG  = 3'h2;
    localparam ST_WDAT = 3'h3;
    localparam ST_RDAT = 3'h4;
    localparam ST_SKIP = 3'h5;

    wire [2:0] synced;
    reg        scl_d;
    reg        sda_d;
    reg  [2:0] state;
    reg  [3:0] bitcnt;
    reg  [7:0] shreg;
    reg  [1:0] reg_ptr;
    reg        ptr_bad;
    reg        ack_phase;
    reg        hs_mode;
    reg        first_byte;
    reg        converter_enable_gate;
    reg        floor_free;
    reg        roof_free;
    reg  [5:0] floor_voltage_code;
    reg  [5:0] roof_voltage_code;
    reg  [5:0] operating_mode_control;
    reg  [7:0] discharge_status_ramp_control;
    reg  [7:0] rd_byte;
    reg  [1:0] voltage_select_pin_sync;
    reg  [1:0] good_sync;

    bcr_sync u_sync (
        .mclk    (mclk),
        .reset   (reset),
        .pin_in  ({enable_pin, sda_in, scl_in}),
        .pin_out (synced)
    );
    wire en_s  = synced[2];
    wire sda_s = synced[1];
    wire scl_s = synced[0];
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

    // ----------------------------------------
    // readback mux
    // ----------------------------------------
    function [7:0] read_mux;
        input [1:0] ptr;
        input       bad;
        input       hs;
        begin
            if (bad)
                read_mux = hs ? `BCR_UNMAP_HS : `BCR_UNMAP_FS;
            else case (ptr)
                `BCR_OFF_FLOOR: read_mux = {converter_enable_gate, floor_free,
                                            floor_voltage_code};
                `BCR_OFF_ROOF:  read_mux = {converter_enable_gate, roof_free,
                                            roof_voltage_code};
                `BCR_OFF_MODE:  read_mux = {2'h0, operating_mode_control};
                default:        read_mux = discharge_status_ramp_control;
            endcase
        end
    endfunction

    always @* begin
        rd_byte = read_mux(reg_ptr, ptr_bad, hs_mode);
    end

    // ----------------------------------------
    // serial slave and register file
    // ----------------------------------------
    always @(posedge mclk) begin
        if (reset) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            state <= ST_IDLE;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            reg_ptr <= 2'h0;
            ptr_bad <= 1'b0;
            ack_phase <= 1'b0;
            hs_mode <= 1'b0;
            first_byte <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            converter_enable_gate <= `BCR_RST_GATE;
            floor_free <= `BCR_RST_FREE6;
            roof_free <= `BCR_RST_FREE6;
            floor_voltage_code <= FLOOR_DEFAULT;
            roof_voltage_code <= ROOF_DEFAULT;
            operating_mode_control <= `BCR_RST_MODE;
            discharge_status_ramp_control <= `BCR_RST_RAMP;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            discharge_status_ramp_control[`BCR_GOOD_BIT] <= good_sync[1];
            if (!en_s) begin
                // hardware shutdown: port ignores the bus
                state <= ST_IDLE;
                sda_oe <= 1'b0;
                hs_mode <= 1'b0;
            end else if (stop_c) begin
                state <= ST_IDLE;
                sda_oe <= 1'b0;
                hs_mode <= 1'b0;
            end else if (start_c) begin
                state <= ST_ADDR;
                bitcnt <= 4'h0;
                ack_phase <= 1'b0;
                sda_oe <= 1'b0;
                first_byte <= 1'b1;
            end else if (state != ST_IDLE && scl_rise && !ack_phase) begin
                // while sending, the shifter holds the outgoing byte
                if (state != ST_RDAT)
                    shreg <= {shreg[6:0], sda_s};
                bitcnt <= bitcnt + 4'h1;
            end else if (state == ST_RDAT && scl_rise && ack_phase) begin
                // host nack ends the read, so sda is free for the stop
                if (sda_s)
                    state <= ST_SKIP;
            end else if (state != ST_IDLE && scl_fall) begin
                if (ack_phase) begin
                    ack_phase <= 1'b0;
                    bitcnt <= 4'h0;
                    sda_oe <= (state == ST_RDAT) ? ~rd_byte[7] : 1'b0;
                    shreg <= (state == ST_RDAT) ? {rd_byte[6:0], 1'b0} : shreg;
                end else if (state == ST_RDAT) begin
                    if (bitcnt == 4'h8) begin
                        // master ack/nack sampled next; release line
                        sda_oe <= 1'b0;
                        ack_phase <= 1'b1;
                    end else begin
                        sda_oe <= ~shreg[7];
                        shreg <= {shreg[6:0], 1'b0};
                    end
                end else if (bitcnt == 4'h8) begin
                    ack_phase <= 1'b1;
                    case (state)
                        ST_ADDR: begin
                            if (first_byte && shreg[7:3] == `BCR_HS_CODE) begin
                                hs_mode <= 1'b1;
                                state <= ST_SKIP;
                            end else if (shreg[7:1] == DEV_ADDR) begin
                                sda_oe <= 1'b1;
                                state <= shreg[0] ? ST_RDAT : ST_REG;
                            end else begin
                                state <= ST_SKIP;
                            end
                            first_byte <= 1'b0;
                        end
                        ST_REG: begin
                            sda_oe <= 1'b1;
                            reg_ptr <= shreg[1:0];
                            ptr_bad <= (shreg[7:2] != 6'h00);
                            state <= ST_WDAT;
                        end
                        ST_WDAT: begin
                            sda_oe <= 1'b1;
                            // update lands at the last data bit's falling edge
                            if (!ptr_bad) begin
                                case (reg_ptr)
                                    `BCR_OFF_FLOOR: begin
                                        converter_enable_gate <= shreg[`BCR_GATE_BIT];
                                        floor_free <= shreg[6];
                                        floor_voltage_code <= shreg[5:0];
                                    end
                                    `BCR_OFF_ROOF: begin
                                        converter_enable_gate <= shreg[`BCR_GATE_BIT];
                                        roof_free <= shreg[6];
                                        roof_voltage_code <= shreg[5:0];
                                    end
                                    `BCR_OFF_MODE: operating_mode_control <= shreg[5:0];
                                    default: begin
                                        discharge_status_ramp_control[7:6] <= shreg[7:6];
                                        discharge_status_ramp_control[4:0] <= shreg[4:0];
                                    end
                                endcase
                            end
                        end
                        default: state <= ST_SKIP;
                    endcase
                end
            end
        end
    end

    // ----------------------------------------
    // converter control outputs
    // ----------------------------------------
    always @(posedge mclk) begin
        if (reset) begin
            converter_run <= 1'b0;
            discharge_on <= 1'b0;
            force_pwm <= 1'b0;
            target_code <= 6'h00;
            ramp_rate_select <= `BCR_RAMP_NOW;
            voltage_select_pin_sync <= 2'h0;
            good_sync <= 2'h0;
        end else begin
            // both pins come from outside this clock, so two flops first
            voltage_select_pin_sync <= {voltage_select_pin_sync[0], voltage_select_pin};
            good_sync <= {good_sync[0], in_regulation};
            converter_run <= converter_enable_gate & en_s;
            discharge_on <= ~(converter_enable_gate & en_s)
                            & discharge_status_ramp_control[`BCR_DISCH_BIT];
            target_code <= voltage_select_pin_sync[1] ? roof_voltage_code
                                        : floor_voltage_code;
            ramp_rate_select <= discharge_status_ramp_control[2:0];
            case (operating_mode_control[3:2])
                `BCR_OVR_FOLLOW: force_pwm <= voltage_select_pin_sync[1]
                    & ~operating_mode_control[`BCR_ROOF_MODE_BIT];
                `BCR_OVR_PWM:    force_pwm <= 1'b1;
                default:         force_pwm <= 1'b0;
            endcase
        end
    end
endmodule // bcr_regs

// ===== bcr_regs_chk.sv
`timescale 1ns/100ps
module bcr_chk (
    // clock, reset, bus
    input wire       mclk,
    input wire       reset,
    input wire       scl_in,
    input wire       sda_in,
    input wire       sda_out,
    input wire       sda_oe,
    // converter side
    input wire       enable_pin,
    input wire       voltage_select_pin,
    input wire       in_regulation,
    input wire       converter_run,
    input wire       discharge_on,
    input wire       force_pwm,
    input wire [5:0] target_code,
    input wire [2:0] ramp_rate_select
);
    // ----------------
    // pin-low counter
    // ----------------
    // six cycles of margin cover the pin synchroniser latency
    reg [3:0] low_cnt;
    always @(posedge mclk) begin
        if (reset || enable_pin)
            low_cnt <= 4'h0;
        else if (low_cnt != 4'hf)
            low_cnt <= low_cnt + 4'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    a_sda_data_low: assert property (sda_out == 1'b0)
        else $error("sda data not low");
    a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("sda driven while scl high");
    a_sda_hold_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("sda moved during scl high");
    a_pin_off_run: assert property (low_cnt > 4'h5 |-> !converter_run)
        else $error("run with enable pin low");
    a_pin_off_bus: assert property (low_cnt > 4'h5 |-> !sda_oe)
        else $error("bus answered with pin low");
    a_run_needs_pin: assert property ($rose(converter_run) |-> enable_pin)
        else $error("run rose with pin low");
    a_dis_when_off: assert property (converter_run [*2] |-> !discharge_on)
        else $error("discharge while running");
    a_reset_state: assert property ($fell(reset) |-> ramp_rate_select == 3'h7 && !sda_oe
        && !force_pwm && target_code == 6'h00 && !discharge_on)
        else $error("bad state after reset");
    c_ack: cover property ($rose(sda_oe));
    c_run_off: cover property ($fell(converter_run));
    c_discharge: cover property ($rose(discharge_on));
endmodule // bcr_chk
bind bcr_regs bcr_chk chk_u (.mclk(mclk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .enable_pin(enable_pin),
    .voltage_select_pin(voltage_select_pin), .in_regulation(in_regulation),
    .converter_run(converter_run), .discharge_on(discharge_on), .force_pwm(force_pwm),
    .target_code(target_code), .ramp_rate_select(ramp_rate_select));

// ===== bcr_host.sv
`timescale 1ns/100ps
module bcr_host (
    // bus lines
    output logic scl,
    output logic sda_low,
    input  wire  sda
);
    // ----------------
    // frame tasks
    // ----------------
    // scl idles high between frames; sda only pulled, never driven high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic bit_io(input logic b, output logic r);
        #31 sda_low = !b;
        #31 scl = 1'b1;
        #31 r = sda;
        #32 scl = 1'b0;
    endtask
    task automatic start;
        #31 sda_low = 1'b0;
        #31 scl = 1'b1;
        #31 sda_low = 1'b1;
        #31 scl = 1'b0;
    endtask
    task automatic stop;
        #31 sda_low = 1'b1;
        #31 scl = 1'b1;
        #31 sda_low = 1'b0;
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic get_byte(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, r);
    endtask
endmodule // bcr_host

// ===== bcr_regs_tb_top.sv
`timescale 1ns/100ps
module bcr_regs_tb_top;
    // ----------------
    // bench
    // ----------------
    logic       mclk = 1'b0;
    logic       reset = 1'b1;
    logic       enable_pin = 1'b1;
    logic       voltage_select_pin = 1'b0;
    logic       in_regulation = 1'b0;
    wire        scl, sda_low, sda_out, sda_oe, converter_run, discharge_on, force_pwm;
    wire  [5:0] target_code;
    wire  [2:0] ramp_rate_select;
    wire        sda = !(sda_oe && !sda_out || sda_low);
    int         error_cnt = 0;
    int         check_count = 0;
    always #5 mclk = ~mclk;
    bcr_regs #(.FLOOR_DEFAULT(6'h10), .ROOF_DEFAULT(6'h20), .DEV_ADDR(7'h48)) dut_u (
        .mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .enable_pin(enable_pin), .voltage_select_pin(voltage_select_pin),
        .in_regulation(in_regulation), .converter_run(converter_run),
        .discharge_on(discharge_on), .force_pwm(force_pwm), .target_code(target_code),
        .ramp_rate_select(ramp_rate_select));
    bcr_host host_u (.scl(scl), .sda_low(sda_low), .sda(sda));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic settle;
        repeat (8) @(negedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic exp_ack);
        logic k;
        host_u.start();
        host_u.put_byte(8'h90, k);
        chk({7'h0, k}, {7'h0, exp_ack});
        host_u.put_byte(a, k);
        host_u.put_byte(d, k);
        chk({7'h0, k}, {7'h0, exp_ack});
        host_u.stop();
        settle;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic       k;
        logic [7:0] d;
        host_u.start();
        host_u.put_byte(8'h90, k);
        host_u.put_byte(a, k);
        host_u.start();
        host_u.put_byte(8'h91, k);
        host_u.get_byte(d);
        host_u.stop();
        chk(d, exp);
    endtask
    task automatic t_defaults;
        rdchk(8'h00, 8'h90);
        rdchk(8'h01, 8'ha0);
        rdchk(8'h02, 8'h00);
        rdchk(8'h03, 8'h47);
        rdchk(8'h04, 8'h00);
        chk({2'h0, target_code}, 8'h10);
        chk({7'h0, converter_run}, 8'h01);
    endtask
    task automatic t_gate_share;
        wr(8'h00, 8'h7f, 1'b1);
        chk({6'h0, converter_run, discharge_on}, 8'h01);
        rdchk(8'h01, 8'h20);
        wr(8'h01, 8'h95, 1'b1);
        rdchk(8'h00, 8'hff);
        @(negedge mclk) voltage_select_pin <= 1'b1;
        settle;
        chk({2'h0, target_code}, 8'h15);
        @(negedge mclk) voltage_select_pin <= 1'b0;
        settle;
        chk({2'h0, target_code}, 8'h3f);
        chk({7'h0, converter_run}, 8'h01);
    endtask
    task automatic t_modes;
        for (int m = 0; m < 8; m++) begin
            wr(8'h02, {4'hc, m[2:1], m[0], 1'b1}, 1'b1);
            for (int s = 0; s < 2; s++) begin
                @(negedge mclk) voltage_select_pin <= s[0];
                settle;
                chk({7'h0, force_pwm}, {7'h0, m[2:1] == 2'h2 || m[2:1] == 2'h0 && s == 1 && !m[0]});
            end
        end
        @(negedge mclk) voltage_select_pin <= 1'b0;
        rdchk(8'h02, 8'h0f);
    endtask
    task automatic t_ramp;
        for (int r = 0; r < 8; r++) begin
            wr(8'h03, {5'h0c, r[2:0]}, 1'b1);
            chk({5'h0, ramp_rate_select}, {5'h0, r[2:0]});
        end
        @(negedge mclk) in_regulation <= 1'b1;
        rdchk(8'h03, 8'h67);
        wr(8'h03, 8'h07, 1'b1);
        wr(8'h00, 8'h3f, 1'b1);
        chk({6'h0, converter_run, discharge_on}, 8'h00);
        wr(8'h00, 8'h90, 1'b1);
    endtask
    task automatic t_pin_off;
        @(negedge mclk) enable_pin <= 1'b0;
        settle;
        chk({7'h0, converter_run}, 8'h00);
        wr(8'h01, 8'h00, 1'b0);
        @(negedge mclk) enable_pin <= 1'b1;
        settle;
        rdchk(8'h01, 8'h95);
    endtask
    task automatic t_hs;
        logic k;
        host_u.start();
        host_u.put_byte(8'h08, k);
        chk({7'h0, k}, 8'h00);
        rdchk(8'h04, 8'hff);
        rdchk(8'h04, 8'h00);
    endtask
    task automatic t_reset;
        @(negedge mclk) reset <= 1'b1;
        repeat (5) @(negedge mclk);
        reset <= 1'b0;
        settle;
        rdchk(8'h01, 8'ha0);
        rdchk(8'h02, 8'h00);
    endtask
    initial begin
        #500_000;
        error_cnt++;
        give_verdict;
    end
    initial begin
        repeat (5) @(negedge mclk);
        reset <= 1'b0;
        settle;
        t_defaults;
        t_gate_share;
        t_modes;
        t_ramp;
        t_pin_off;
        t_hs;
        t_reset;
        give_verdict;
    end
endmodule // bcr_regs_tb_top
